// ==== rtl/pps_pkg.sv ====
// shared constants and carrier types for the protection sequencer
package pps_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;

  // blanking and timer figures in their own units
  localparam int unsigned CL_BLANK_NS   = 300;
  localparam int unsigned OC_BLANK_NS   = 250;
  localparam int unsigned OV_BLANK_US   = 22;
  localparam int unsigned UV_BLANK_US   = 55;
  localparam int unsigned RESTART_US    = 180;
  localparam int unsigned RECOVER_MS    = 80;
  localparam int unsigned BROWNOUT_MS   = 50;

  // least times round up to whole cycles
  localparam int unsigned CL_BLANK_CYC =
    (CL_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OC_BLANK_CYC =
    (OC_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OV_BLANK_CYC =
    (OV_BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UV_BLANK_CYC =
    (UV_BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESTART_CYC =
    (RESTART_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_CYC =
    (RECOVER_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BROWNOUT_CYC =
    (BROWNOUT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // consecutive restart-cycle over-current events that trip the fault
  localparam logic [1:0] OC_TRIP_COUNT = 2'h2;

  // comparator outputs from the analog front end
  typedef struct packed {
    logic cs_over_limit;   // sense above cycle limit level
    logic cs_over_fault;   // sense above fault level
    logic feedback_over_trip;    // feedback above overvoltage trip
    logic feedback_over_resume;  // feedback still above overvoltage resume
    logic feedback_under_trip;   // feedback below undervoltage trip
    logic feedback_under_resume; // feedback still below trip plus hysteresis
    logic line_above_on;   // line peak above brown-in level
    logic line_below_off;  // line peak below brownout level
  } pps_cmp_t;

  // switch-stage state as seen by the sequencer
  typedef enum logic [1:0] {
    PPS_IDLE,
    PPS_ON,
    PPS_OFF
  } pps_sw_t;

endpackage : pps_pkg

// ==== rtl/pps_sequencer.sv ====
// fault sequencer gating switch drive for a boost power factor stage
// Summary of operation
// R01: a sensed current above the cycle limit after blanking ends the pulse.
// R02: the cycle limit comparator is ignored for 300 ns after each turn-on.
// R03: the fault-level comparator is ignored for 250 ns after each turn-on.
// R04: fault level seen in two consecutive restart cycles declares a fault.
// R05: a declared over-current fault sets its flag and holds drive off.
// R06: the fault clears after 80 ms, or on brown-in, brownout or lockout.
// R07: feedback above the overvoltage trip for 22 us disables drive.
// R08: after overvoltage, switching resumes once feedback falls to resume.
// R09: feedback below the undervoltage trip for 55 us stops operation.
// R10: undervoltage is left only when feedback rises past the hysteresis.
// R11: while undervoltage holds, compensation is discharged, low power.
// R12: a 180 us timer from each turn-off forces a turn-on with no valley.
// R13: brownout is confirmed only after the line stays low for 50 ms.
// R14: a restart cycle with no fault-level event clears the count.
`timescale 1ns/10ps
module pps_sequencer
  import pps_pkg::*;
#(
  parameter int unsigned RECOVER_CYCLES  = RECOVER_CYC,
  parameter int unsigned BROWNOUT_CYCLES = BROWNOUT_CYC,
  parameter int unsigned RESTART_CYCLES  = RESTART_CYC,
  parameter int unsigned UV_CYCLES       = UV_BLANK_CYC,
  parameter int unsigned OV_CYCLES       = OV_BLANK_CYC
) (
  // clock and reset
  input  wire logic     clk,
  input  wire logic     rst,
  // supply and timing inputs
  input  wire logic     supply_lockout,
  input  wire logic     valley_seen,
  input  wire logic     on_time_done,
  input  wire pps_cmp_t cmp,
  // drive and status outputs
  output logic          gate_drive,
  output logic          comp_discharge,
  output logic          low_power,
  output logic          overcurrent_shutdown,
  output logic          overvoltage_guard,
  output logic          undervoltage_guard,
  output logic          brownout_flag,
  output logic          cycle_current_limit
);

  localparam int CW = 24;

  // saturating counter step
  function automatic logic [CW-1:0] cnt_up(input logic [CW-1:0] c);
    cnt_up = (c == {CW{1'b1}}) ? c : c + {{(CW-1){1'b0}}, 1'b1};
  endfunction : cnt_up

  // compare counter against a cycle count
  function automatic logic reached(input logic [CW-1:0] c,
                                   input int unsigned n);
    reached = (c >= CW'(n));
  endfunction : reached

  pps_sw_t       sw_q, sw_d;
  logic [CW-1:0] on_cnt_q, on_cnt_d;
  logic [CW-1:0] off_cnt_q, off_cnt_d;
  logic [CW-1:0] rec_cnt_q, rec_cnt_d;
  logic [CW-1:0] bo_cnt_q, bo_cnt_d;
  logic [CW-1:0] ov_cnt_q, ov_cnt_d;
  logic [CW-1:0] uv_cnt_q, uv_cnt_d;
  logic          restart_q, restart_d;
  logic          oc_hit_q, oc_hit_d;
  logic [1:0]    oc_cnt_q, oc_cnt_d;
  logic          ocf_q, ocf_d;
  logic          ov_q, ov_d;
  logic          uv_q, uv_d;
  logic          bo_q, bo_d;
  logic          run_q, run_d;
  logic          lim_q, lim_d;
  logic          gate_q, gate_d;

  logic cl_live, oc_live, allow, end_pulse, bi_evt, bo_evt, clr_oc;

  // blanked comparator views
  always_comb begin
    // R02 cycle limit blank
    cl_live = cmp.cs_over_limit && reached(on_cnt_q, CL_BLANK_CYC);
    // R03 fault level blank
    oc_live = cmp.cs_over_fault && reached(on_cnt_q, OC_BLANK_CYC);
  end

  // line, supply and fault bookkeeping
  always_comb begin
    bo_cnt_d = cmp.line_below_off ? cnt_up(bo_cnt_q) : '0;
    bo_d     = bo_q;
    run_d    = run_q;
    // R13 brownout confirm timer
    bo_evt   = run_q && !bo_q && reached(bo_cnt_q, BROWNOUT_CYCLES);
    bi_evt   = !supply_lockout && !run_q && cmp.line_above_on;
    if (supply_lockout) begin
      run_d = 1'b0;
      bo_d  = 1'b0;
    end else if (bo_evt) begin
      run_d = 1'b0;
      bo_d  = 1'b1;
    end else if (bi_evt) begin
      run_d = 1'b1;
      bo_d  = 1'b0;
    end
    // R07 overvoltage blanking
    ov_cnt_d = cmp.feedback_over_trip ? cnt_up(ov_cnt_q) : '0;
    ov_d     = ov_q;
    if (!ov_q && reached(ov_cnt_q, OV_CYCLES)) begin
      ov_d = 1'b1;
    // R08 overvoltage resume level
    end else if (ov_q && !cmp.feedback_over_resume) begin
      ov_d = 1'b0;
    end
    // R09 undervoltage blanking
    uv_cnt_d = cmp.feedback_under_trip ? cnt_up(uv_cnt_q) : '0;
    uv_d     = uv_q;
    if (!uv_q && reached(uv_cnt_q, UV_CYCLES)) begin
      uv_d = 1'b1;
    // R10 undervoltage hysteresis exit
    end else if (uv_q && !cmp.feedback_under_resume) begin
      uv_d = 1'b0;
    end
    // R06 recovery timer and clear events
    rec_cnt_d = ocf_q ? cnt_up(rec_cnt_q) : '0;
    clr_oc    = supply_lockout || bo_evt || bi_evt ||
                reached(rec_cnt_q, RECOVER_CYCLES);
  end

  assign allow = run_q && !ocf_q && !ov_q && !uv_q;

  // switching sequence and over-current counting
  always_comb begin
    sw_d      = sw_q;
    on_cnt_d  = '0;
    off_cnt_d = '0;
    restart_d = restart_q;
    oc_hit_d  = oc_hit_q;
    oc_cnt_d  = oc_cnt_q;
    ocf_d     = ocf_q;
    lim_d     = 1'b0;
    gate_d    = 1'b0;
    // R01 cycle limit ends pulse
    end_pulse = on_time_done || cl_live;
    case (sw_q)
      PPS_IDLE: begin
        restart_d = 1'b1;
        if (allow) begin
          sw_d   = PPS_ON;
          gate_d = 1'b1;
        end
      end
      PPS_ON: begin
        on_cnt_d = cnt_up(on_cnt_q);
        gate_d   = 1'b1;
        if (oc_live) begin
          oc_hit_d = 1'b1;
        end
        if (!allow || end_pulse || oc_live) begin
          sw_d   = PPS_OFF;
          gate_d = 1'b0;
          lim_d  = cl_live;
          if (restart_q) begin
            // R04 count restart cycle events
            if (oc_hit_q || oc_live) begin
              oc_cnt_d = oc_cnt_q + 2'h1;
            // R14 clean restart cycle clears
            end else begin
              oc_cnt_d = 2'h0;
            end
          end
        end
      end
      PPS_OFF: begin
        off_cnt_d = cnt_up(off_cnt_q);
        oc_hit_d  = 1'b0;
        if (!allow) begin
          sw_d = PPS_IDLE;
        // R12 forced restart turn-on
        end else if (reached(off_cnt_q, RESTART_CYCLES)) begin
          sw_d      = PPS_ON;
          restart_d = 1'b1;
          gate_d    = 1'b1;
        end else if (valley_seen) begin
          sw_d      = PPS_ON;
          restart_d = 1'b0;
          gate_d    = 1'b1;
        end
      end
      default: begin
        sw_d = PPS_IDLE;
      end
    endcase
    // R05 fault latch holds drive off
    if (oc_cnt_d >= OC_TRIP_COUNT) begin
      ocf_d    = 1'b1;
      oc_cnt_d = 2'h0;
    end else if (clr_oc) begin
      ocf_d = 1'b0;
    end
    if (ocf_d || !allow) begin
      gate_d = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_q      <= PPS_IDLE;
      on_cnt_q  <= '0;
      off_cnt_q <= '0;
      rec_cnt_q <= '0;
      bo_cnt_q  <= '0;
      ov_cnt_q  <= '0;
      uv_cnt_q  <= '0;
      restart_q <= 1'b1;
      oc_hit_q  <= 1'b0;
      oc_cnt_q  <= 2'h0;
      ocf_q     <= 1'b0;
      ov_q      <= 1'b0;
      uv_q      <= 1'b0;
      bo_q      <= 1'b0;
      run_q     <= 1'b0;
      lim_q     <= 1'b0;
      gate_q    <= 1'b0;
    end else begin
      sw_q      <= sw_d;
      on_cnt_q  <= on_cnt_d;
      off_cnt_q <= off_cnt_d;
      rec_cnt_q <= rec_cnt_d;
      bo_cnt_q  <= bo_cnt_d;
      ov_cnt_q  <= ov_cnt_d;
      uv_cnt_q  <= uv_cnt_d;
      restart_q <= restart_d;
      oc_hit_q  <= oc_hit_d;
      oc_cnt_q  <= oc_cnt_d;
      ocf_q     <= ocf_d;
      ov_q      <= ov_d;
      uv_q      <= uv_d;
      bo_q      <= bo_d;
      run_q     <= run_d;
      lim_q     <= lim_d;
      gate_q    <= gate_d;
    end
  end

  // outputs straight from flip-flops
  assign gate_drive           = gate_q;
  // R11 discharge and low power
  assign comp_discharge       = uv_q;
  assign low_power            = uv_q;
  assign overcurrent_shutdown = ocf_q;
  assign overvoltage_guard    = ov_q;
  assign undervoltage_guard   = uv_q;
  assign brownout_flag        = bo_q;
  assign cycle_current_limit  = lim_q;

  // checks
  chk_cl_blank: assert property (@(posedge clk) disable iff (rst) // R02
    (sw_q == PPS_ON && on_cnt_q < CW'(CL_BLANK_CYC) && !on_time_done
     && !cmp.cs_over_fault && allow) |=> gate_q)
    else $error("cycle limit acted inside blanking");
  chk_cl_end: assert property (@(posedge clk) disable iff (rst) // R01
    (sw_q == PPS_ON && cl_live) |=> (!gate_q && lim_q))
    else $error("cycle limit did not end pulse");
  chk_oc_blank: assert property (@(posedge clk) disable iff (rst) // R03
    (sw_q == PPS_ON && cmp.cs_over_fault && !reached(on_cnt_q, OC_BLANK_CYC))
    |=> !oc_hit_q || $past(oc_hit_q))
    else $error("fault level seen inside blanking");
  chk_oc_hold: assert property (@(posedge clk) disable iff (rst) // R05
    ocf_q |-> !gate_q)
    else $error("drive on during over-current fault");
  chk_oc_trip: assert property (@(posedge clk) disable iff (rst) // R04
    $rose(ocf_q) |-> $past(oc_cnt_q) == 2'h1)
    else $error("fault declared without prior restart event");
  chk_oc_clear: assert property (@(posedge clk) disable iff (rst) // R06
    (ocf_q && supply_lockout) |=> !ocf_q)
    else $error("lockout did not clear fault");
  chk_ov_blank: assert property (@(posedge clk) disable iff (rst) // R07
    $rose(ov_q) |-> $past(ov_cnt_q) >= CW'(OV_CYCLES))
    else $error("overvoltage without full blanking");
  chk_ov_resume: assert property (@(posedge clk) disable iff (rst) // R08
    (ov_q && cmp.feedback_over_resume) |=> ov_q)
    else $error("overvoltage left above resume level");
  chk_uv_blank: assert property (@(posedge clk) disable iff (rst) // R09
    $rose(uv_q) |-> $past(uv_cnt_q) >= CW'(UV_CYCLES))
    else $error("undervoltage without full blanking");
  chk_uv_hyst: assert property (@(posedge clk) disable iff (rst) // R10
    (uv_q && cmp.feedback_under_resume) |=> (uv_q && comp_discharge))
    else $error("undervoltage left inside hysteresis");
  chk_bo_wait: assert property (@(posedge clk) disable iff (rst) // R13
    $rose(bo_q) |-> $past(bo_cnt_q) >= CW'(BROWNOUT_CYCLES))
    else $error("brownout confirmed early");
  chk_restart: assert property (@(posedge clk) disable iff (rst) // R12
    (sw_q == PPS_OFF && allow && !ocf_d
     && reached(off_cnt_q, RESTART_CYCLES)) |=> (gate_q && restart_q))
    else $error("restart timer did not force turn-on");
  chk_oc_recover: assert property (@(posedge clk) disable iff (rst) // R06
    (ocf_q && reached(rec_cnt_q, RECOVER_CYCLES)) |=> !ocf_q)
    else $error("recovery timer did not clear fault");
  chk_uv_stop: assert property (@(posedge clk) disable iff (rst) // R09
    uv_q |=> !gate_q)
    else $error("drive on during undervoltage");

endmodule : pps_sequencer

// ==== verification/pps_stage_model.sv ====
// boost stage stand-in: on-time end and valley detect
`timescale 1ns/10ps
module pps_stage_model #(
  parameter int ON_LEN  = 80,
  parameter int VAL_LEN = 20
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // switch drive and valley enable
  input  wire logic gate_drive,
  input  wire logic valley_en,
  // stage answers
  output logic      on_time_done,
  output logic      valley_seen
);
  logic prev;
  int   cnt;

  // count cycles spent in the present switch state
  always_ff @(posedge clk) begin
    prev <= gate_drive;
    if (rst || gate_drive != prev) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // on-time ends late; valley rings only when enabled
  assign on_time_done = gate_drive && cnt >= ON_LEN;
  assign valley_seen  = valley_en && !gate_drive && cnt >= VAL_LEN;
endmodule : pps_stage_model

// ==== verification/test_pps_sequencer.sv ====
// self-checking bench for the protection sequencer
`timescale 1ns/10ps
module test_pps_sequencer;
  import pps_pkg::*;
  localparam int RC = 200;
  localparam int SC = 50;
  logic     clk, rst, lock, val_en, vseen, otd;
  logic     gd, cd, lp, ocs, ovg, uvg, bof, ccl;
  pps_cmp_t c;
  int       fail_count = 0;
  int       n_tests = 0;
  int       cyc = 0;
  int       k;

  // design with shortened timers
  pps_sequencer #(.RECOVER_CYCLES(RC), .BROWNOUT_CYCLES(100),
    .RESTART_CYCLES(SC), .UV_CYCLES(40), .OV_CYCLES(30)) dut_u (
    .clk(clk), .rst(rst), .supply_lockout(lock), .valley_seen(vseen),
    .on_time_done(otd), .cmp(c), .gate_drive(gd), .comp_discharge(cd),
    .low_power(lp), .overcurrent_shutdown(ocs),
    .overvoltage_guard(ovg), .undervoltage_guard(uvg),
    .brownout_flag(bof), .cycle_current_limit(ccl));

  // far-side stage
  pps_stage_model stage_u (.clk(clk), .rst(rst), .gate_drive(gd),
    .valley_en(val_en), .on_time_done(otd), .valley_seen(vseen));

  // compare one value and count it
  task automatic chk(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : chk

  // move just past the n-th rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // wait for gate drive to reach v, k holds the cycles spent
  task automatic wait_gd(input logic v, input int lim);
    k = 0;
    while (gd !== v && k < lim) begin
      tick(1);
      k++;
    end
    chk(gd, v, "gate drive wait");
  endtask : wait_gd

  // brown-in after reset starts switching
  task automatic t_start;
    chk(gd, 1'b0, "drive during reset");
    rst = 1'b0;
    c.line_above_on = 1'b1;
    wait_gd(1'b1, 5);
    $display("test start done");
  endtask : t_start

  // cycle limit blanked, then ends the pulse
  task automatic t_limit;
    val_en = 1'b1;
    wait_gd(1'b0, 100);
    wait_gd(1'b1, 30);
    c.cs_over_limit = 1'b1;
    tick(30);
    chk(gd, 1'b1, "limit not blanked");
    wait_gd(1'b0, 5);
    chk(k == 1, 1'b1, "limit late");
    chk(ccl, 1'b1, "limit pulse");
    c.cs_over_limit = 1'b0;
    val_en = 1'b0;
    $display("test limit done");
  endtask : t_limit

  // two restart cycles at fault level trip, timer recovers
  task automatic t_oc;
    wait_gd(1'b1, SC + 5);
    chk(k >= SC, 1'b1, "restart too soon");
    c.cs_over_fault = 1'b1;
    k = 0;
    while (ocs !== 1'b1 && k < 300) begin
      tick(1);
      k++;
    end
    chk(ocs, 1'b1, "no fault trip");
    chk(k > SC, 1'b1, "trip on one cycle");
    c.cs_over_fault = 1'b0;
    tick(RC / 2);
    chk(gd, 1'b0, "drive under fault");
    tick(RC / 2 - 20);
    chk(ocs, 1'b1, "fault cleared early");
    tick(30);
    chk(ocs, 1'b0, "fault not recovered");
    $display("test overcurrent done");
  endtask : t_oc

  // overvoltage blank and resume level
  task automatic t_ov;
    c.feedback_over_trip = 1'b1;
    c.feedback_over_resume = 1'b1;
    tick(26);
    chk(ovg, 1'b0, "ov early");
    tick(9);
    chk(ovg, 1'b1, "ov guard");
    chk(gd, 1'b0, "ov drive");
    c.feedback_over_trip = 1'b0;
    tick(10);
    chk(ovg, 1'b1, "ov left early");
    c.feedback_over_resume = 1'b0;
    tick(3);
    chk(ovg, 1'b0, "ov held");
    wait_gd(1'b1, SC + 90);
    $display("test overvoltage done");
  endtask : t_ov

  // undervoltage blank, hysteresis and discharge
  task automatic t_uv;
    c.feedback_under_trip = 1'b1;
    c.feedback_under_resume = 1'b1;
    tick(36);
    chk(uvg, 1'b0, "uv early");
    tick(9);
    chk(uvg, 1'b1, "uv guard");
    chk(gd, 1'b0, "uv drive");
    chk(cd & lp, 1'b1, "uv discharge");
    c.feedback_under_trip = 1'b0;
    tick(10);
    chk(uvg, 1'b1, "uv left early");
    c.feedback_under_resume = 1'b0;
    tick(3);
    chk(uvg | cd, 1'b0, "uv held");
    $display("test undervoltage done");
  endtask : t_uv

  // brownout timer, then brown-in
  task automatic t_bo;
    c.line_above_on = 1'b0;
    c.line_below_off = 1'b1;
    tick(90);
    chk(bof, 1'b0, "bo early");
    tick(15);
    chk(bof, 1'b1, "bo confirm");
    chk(gd, 1'b0, "bo drive");
    c.line_below_off = 1'b0;
    c.line_above_on = 1'b1;
    tick(3);
    chk(bof, 1'b0, "brown-in clear");
    $display("test brownout done");
  endtask : t_bo

  // lockout clears a tripped fault, release restarts the run
  task automatic t_lock;
    c.cs_over_fault = 1'b1;
    k = 0;
    while (ocs !== 1'b1 && k < 300) begin
      tick(1);
      k++;
    end
    chk(ocs, 1'b1, "no second trip");
    c.cs_over_fault = 1'b0;
    lock = 1'b1;
    tick(2);
    chk(ocs, 1'b0, "lockout kept fault");
    chk(gd, 1'b0, "drive under lockout");
    lock = 1'b0;
    wait_gd(1'b1, 5);
    $display("test lockout done");
  endtask : t_lock

  // counts and verdict
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      $display("MISMATCH t=%0t timeout", $time);
      end_sim();
    end
  end

  // main sequence
  initial begin
    rst = 1'b1;
    lock = 1'b0;
    val_en = 1'b0;
    c = '0;
    tick(6);
    t_start();
    t_limit();
    t_oc();
    t_ov();
    t_uv();
    t_bo();
    t_lock();
    end_sim();
  end
endmodule : test_pps_sequencer
